// ===== test/psc_pin_ctrl_tb.sv
// testbench: strap decode, pin drive and switch control of the sink block
module psc_pin_ctrl_tb import psc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic          clk_sys;
    logic          rst;
    logic          chip_enable_n;
    psc_strap_t    mode_strap;
    logic          hv_charger_detect_strap;
    logic          flag_input, debug_accessory, cc2_attached, dcp_detected;
    psc_fault_t    faults;
    psc_host_cfg_t host_cfg;
    logic [2:0]    voltage_select_input;
    logic [3:0]    current_select_input;
    logic          debug_n, general_output_a, general_output_a_oe;
    logic          plug_side_out, plug_side_oe, general_output_b;
    logic          attn_n_o, attn_n_oe, vbus_switch_o, vbus_switch_oe;
    logic          system_enable, i2c_pins_active, bc_detect_enable;
    logic          high_voltage_charger_protocol, attn_line, gate_line;
    psc_mode_t     work_mode;
    logic [6:0]    i2c_target_addr;
    psc_request_t  gpio_request;
    logic [15:0]   e;
    int            n_errors = 0;
    int            cmp_count = 0;
    int            cycles = 0;

    psc_pin_ctrl psc_pin_ctrl_i (.clk_sys, .rst, .chip_enable_n, .mode_strap,
        .hv_charger_detect_strap, .flag_input, .debug_accessory,
        .cc2_attached, .dcp_detected, .faults, .host_cfg,
        .voltage_select_input, .current_select_input, .debug_n,
        .general_output_a, .general_output_a_oe, .plug_side_out,
        .plug_side_oe, .general_output_b, .attn_n_o, .attn_n_oe,
        .vbus_switch_o, .vbus_switch_oe, .system_enable, .work_mode,
        .i2c_target_addr, .i2c_pins_active, .bc_detect_enable,
        .high_voltage_charger_protocol, .gpio_request);

    psc_source_model psc_source_model_i (.clk_sys, .attn_n_o, .attn_n_oe,
        .vbus_switch_o, .vbus_switch_oe, .flag_input, .debug_accessory,
        .cc2_attached, .dcp_detected, .faults, .host_cfg,
        .voltage_select_input, .current_select_input, .attn_line,
        .gate_line);

    // ------------------------------------------------------------------
    // clock, hang guard and helpers
    // ------------------------------------------------------------------
    // 200 MHz system clock
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // whole run needs about 800 cycles, so 5000 means a hang
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h, expected %h", $time, got,
                     exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask

    // bounded wait, since enable takes sync plus strap settle time
    task automatic enable_with(input psc_strap_t strap, input logic hv);
        int n;
        @(negedge clk_sys);
        mode_strap = strap;
        hv_charger_detect_strap = hv;
        chip_enable_n = 1'b0;
        settle(2);
        chk(16'(system_enable), 16'h0);
        n = 0;
        while (system_enable !== 1'b1 && n < 40) begin
            @(negedge clk_sys);
            n++;
        end
        chk(16'(system_enable), 16'h1);
    endtask

    task automatic disable_all();
        @(negedge clk_sys);
        chip_enable_n = 1'b1;
        settle(5);
        chk(16'({debug_n, system_enable, vbus_switch_oe, attn_n_oe,
                 work_mode, i2c_target_addr}), 16'h1000);
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        chip_enable_n = 1'b1;
        mode_strap = PSC_STRAP_FLOAT;
        hv_charger_detect_strap = 1'b0;
        settle(8);
        chk(16'({debug_n, system_enable, vbus_switch_oe, attn_n_oe,
                 general_output_b, work_mode}), 16'h40);
        rst = 1'b0;
        settle(30);
        chk(16'(system_enable), 16'h0);
        $display("test reset finished");

        // strap levels: high 62h, low 42h, float gpio without address
        enable_with(PSC_STRAP_HIGH, 1'b0);
        chk(16'({work_mode, i2c_target_addr, i2c_pins_active}),
            16'h1c5);
        disable_all();
        enable_with(PSC_STRAP_LOW, 1'b0);
        chk(16'({work_mode, i2c_target_addr, i2c_pins_active}),
            16'h185);
        disable_all();
        enable_with(PSC_STRAP_FLOAT, 1'b0);
        chk(16'({work_mode, i2c_target_addr, i2c_pins_active}),
            16'h200);
        $display("test strap decode finished");

        // gpio: codes clip at 28 V and 3.25 A, host controls ignored
        psc_source_model_i.set_host(7'h7d);
        for (int k = 0; k < 16; k += 3) begin
            psc_source_model_i.set_sel(3'(k), 4'(k));
            settle(3);
            e = {9'h0, (3'(k) > PSC_VSEL_MAX) ? PSC_VSEL_MAX : 3'(k),
                 (4'(k) > PSC_ISEL_MAX) ? PSC_ISEL_MAX : 4'(k)};
            chk(16'(gpio_request), e);
        end
        chk(16'({general_output_a_oe, plug_side_oe, general_output_b,
                 attn_line}), 16'h1);
        psc_source_model_i.set_source(1'b0, 1'b0, 1'b0, 4'h0, 1'b1);
        settle(5);
        chk(16'({gate_line, attn_line}), 16'h3);
        psc_source_model_i.set_source(1'b0, 1'b0, 1'b0, 4'h0, 1'b0);
        settle(5);
        chk(16'(gate_line), 16'h0);
        disable_all();
        $display("test gpio request finished");

        // i2c: every host setting against attach and accessory changes
        enable_with(PSC_STRAP_LOW, 1'b0);
        for (int k = 0; k < 128; k++) begin
            psc_source_model_i.set_source(k[1] ^ k[4], k[0] ^ k[3], 1'b0,
                                          4'h0, 1'b0);
            psc_source_model_i.set_host(7'(k));
            settle(2);
            e = {9'h0, ~(k[1] ^ k[4]), k[6], k[6] & k[5], k[4],
                 k[4] & (k[0] ^ k[3]), k[3] & k[2], ~k[0]};
            chk(16'({debug_n, general_output_a_oe,
                     general_output_a & general_output_a_oe, plug_side_oe,
                     plug_side_out & plug_side_oe, general_output_b,
                     attn_line}),
                e);
        end
        @(negedge clk_sys);
        mode_strap = PSC_STRAP_HIGH;
        psc_source_model_i.set_host(7'h00);
        settle(4);
        chk(16'({work_mode, i2c_target_addr}), 16'hc2);
        for (int j = 0; j < 4; j++) begin
            psc_source_model_i.set_source(1'b0, 1'b0, 1'b0, 4'(1 << j), 1'b0);
            settle(3);
            chk(16'({general_output_b, gate_line}), 16'h3);
        end
        psc_source_model_i.set_source(1'b0, 1'b0, 1'b0, 4'h0, 1'b1);
        settle(1);
        chk(16'(gate_line), 16'h0);
        settle(4);
        chk(16'({gate_line, attn_line}), 16'h2);
        psc_source_model_i.set_host(7'h02);
        settle(3);
        chk(16'({gate_line, attn_line}), 16'h0);
        psc_source_model_i.set_source(1'b0, 1'b0, 1'b0, 4'h0, 1'b0);
        disable_all();
        $display("test i2c pins finished");

        // charger strap: low never goes past basic detection
        enable_with(PSC_STRAP_FLOAT, 1'b0);
        psc_source_model_i.set_source(1'b0, 1'b0, 1'b1, 4'h0, 1'b0);
        settle(3);
        chk(16'({bc_detect_enable, high_voltage_charger_protocol}),
            16'h2);
        disable_all();
        enable_with(PSC_STRAP_FLOAT, 1'b1);
        chk(16'({bc_detect_enable, high_voltage_charger_protocol}),
            16'h3);
        psc_source_model_i.set_source(1'b0, 1'b0, 1'b0, 4'h0, 1'b0);
        settle(3);
        chk(16'({bc_detect_enable, high_voltage_charger_protocol}),
            16'h2);
        disable_all();
        $display("test charger strap finished");
        finish_test();
    end

endmodule // psc_pin_ctrl_tb

// ===== test/psc_source_model.sv
// partner model: adapter, cable attach and host master configuration
module psc_source_model
    import psc_pkg::*;
(
    input  wire logic     clk_sys,
    input  wire logic     attn_n_o,
    input  wire logic     attn_n_oe,
    input  wire logic     vbus_switch_o,
    input  wire logic     vbus_switch_oe,
    output logic          flag_input,
    output logic          debug_accessory,
    output logic          cc2_attached,
    output logic          dcp_detected,
    output psc_fault_t    faults,
    output psc_host_cfg_t host_cfg,
    output logic [2:0]    voltage_select_input,
    output logic [3:0]    current_select_input,
    output logic          attn_line,
    output logic          gate_line
);
    timeunit 1ns;
    timeprecision 1ps;

    // --------------------------------------------------------------
    // open-drain lines
    // --------------------------------------------------------------
    // board pull-ups hold both lines high once released
    assign attn_line = attn_n_oe ? attn_n_o : 1'b1;
    assign gate_line = vbus_switch_oe ? vbus_switch_o : 1'b1;

    // --------------------------------------------------------------
    // stimulus, always applied on the falling edge
    // --------------------------------------------------------------
    // quiet source: nothing attached, no faults, host idle
    initial begin
        flag_input = 1'b0;
        debug_accessory = 1'b0;
        cc2_attached = 1'b0;
        dcp_detected = 1'b0;
        faults = '0;
        host_cfg = '0;
        voltage_select_input = 3'h0;
        current_select_input = 4'h0;
    end

    // adapter and cable side events
    task automatic set_source(input logic dbg, input logic cc2,
                              input logic dcp, input psc_fault_t flt,
                              input logic flg);
        @(negedge clk_sys);
        debug_accessory = dbg;
        cc2_attached = cc2;
        dcp_detected = dcp;
        faults = flt;
        flag_input = flg;
    endtask

    // settings land as levels, one per clock at most
    // far faster than a host on a 400 khz serial clock could write them
    task automatic set_host(input psc_host_cfg_t cfg);
        @(negedge clk_sys);
        host_cfg = cfg;
    endtask

    // setting resistors, already read as codes
    task automatic set_sel(input logic [2:0] v, input logic [3:0] i);
        @(negedge clk_sys);
        voltage_select_input = v;
        current_select_input = i;
    endtask

endmodule // psc_source_model

// ===== verilog/psc_pin_ctrl.sv
// module: pin-level control and status of the sink controller
//
// Behaviour
// [RULE_01] debug pin low when accessory detected
// [RULE_02] strap low: basic charger detection only
// [RULE_03] strap high: hv detection after dcp
// [RULE_04] dual pin a drives host level
// [RULE_05] mode strap: high 62h, low 42h, float gpio
// [RULE_06] plug side output low cc1, high cc2
// [RULE_07] gpio mode: setting pins give request
// [RULE_08] gpio request capped at 28v/3.25a
// [RULE_09] i2c mode: setting pins are i2c
// [RULE_10] host master configures and reads status
// [RULE_11] attention open-drain low when requested
// [RULE_12] enable low-active, internally pulled up
// [RULE_13] fault output high on any fault
// [RULE_14] multipurpose output as general output
// [RULE_15] default flag disables switch, raises attention (code raises attention in i2c mode only)
// [RULE_16] interrupt-only flag leaves switch alone
// [RULE_17] switch open-drain, off on fault/flag
// [RULE_18] whole system disabled while enable high
// [RULE_19] host keeps serial clock at 400khz
// [RULE_20] straps sampled once after enable
// [RULE_21] flag and enable synchronised first
module psc_pin_ctrl
    import psc_pkg::*;
(
    input  wire logic          clk_sys,
    input  wire logic          rst,
    input  wire logic          chip_enable_n,
    input  wire psc_strap_t    mode_strap,
    input  wire logic          hv_charger_detect_strap,
    input  wire logic          flag_input,
    input  wire logic          debug_accessory,
    input  wire logic          cc2_attached,
    input  wire logic          dcp_detected,
    input  wire psc_fault_t    faults,
    input  wire psc_host_cfg_t host_cfg,
    input  wire logic [2:0]    voltage_select_input,
    input  wire logic [3:0]    current_select_input,
    output logic               debug_n,
    output logic               general_output_a,
    output logic               general_output_a_oe,
    output logic               plug_side_out,
    output logic               plug_side_oe,
    output logic               general_output_b,
    output logic               attn_n_o,
    output logic               attn_n_oe,
    output logic               vbus_switch_o,
    output logic               vbus_switch_oe,
    output logic               system_enable,
    output psc_mode_t          work_mode,
    output logic [6:0]         i2c_target_addr,
    output logic               i2c_pins_active,
    output logic               bc_detect_enable,
    output logic               high_voltage_charger_protocol,
    output psc_request_t       gpio_request
);

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    logic [1:0] en_sync;
    logic [1:0] flag_sync;

    // [RULE_21] two-stage sync
    // reset leaves enable deasserted: the pin idles high via pull-up
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            en_sync   <= 2'b00;
            flag_sync <= 2'b00;
        end else begin
            en_sync   <= {en_sync[0], ~chip_enable_n};
            flag_sync <= {flag_sync[0], flag_input};
        end
    end

    logic en_s;
    logic flag_s;
    assign en_s   = en_sync[1];
    assign flag_s = flag_sync[1];

    // ------------------------------------------------------------------
    // enable sequencer and strap capture
    // ------------------------------------------------------------------
    psc_state_t   state;
    psc_state_t   next_state;
    logic [4:0]   cnt;
    logic [4:0]   next_cnt;
    psc_mode_t    next_work_mode;
    logic [6:0]   next_addr;
    logic         hv_strap;
    logic         next_hv_strap;

    // [RULE_12] [RULE_18] [RULE_20] enable and capture
    // straps are only caught after a settle window, not under reset
    always_comb begin
        next_state     = state;
        next_cnt       = cnt;
        next_work_mode = work_mode;
        next_addr      = i2c_target_addr;
        next_hv_strap  = hv_strap;
        case (state)
            PSC_ST_DISABLED: begin
                next_cnt       = '0;
                next_work_mode = PSC_MODE_OFF;
                next_addr      = PSC_ADDR_NONE;
                next_hv_strap  = 1'b0;
                if (en_s) begin
                    next_state = PSC_ST_SAMPLE;
                end
            end
            PSC_ST_SAMPLE: begin
                next_cnt = cnt + 5'h01;
                if (!en_s) begin
                    next_state = PSC_ST_DISABLED;
                end else if (cnt == PSC_STRAP_CNT_LAST) begin
                    next_state    = PSC_ST_RUN;
                    next_hv_strap = hv_charger_detect_strap;
                    // [RULE_05] three-state decode
                    if (mode_strap == PSC_STRAP_HIGH) begin
                        next_work_mode = PSC_MODE_I2C;
                        next_addr      = PSC_ADDR_STRAP_HIGH;
                    end else if (mode_strap == PSC_STRAP_LOW) begin
                        next_work_mode = PSC_MODE_I2C;
                        next_addr      = PSC_ADDR_STRAP_LOW;
                    end else begin
                        next_work_mode = PSC_MODE_GPIO;
                        next_addr      = PSC_ADDR_NONE;
                    end
                end
            end
            PSC_ST_RUN: begin
                if (!en_s) begin
                    next_state = PSC_ST_DISABLED;
                end
            end
            default: begin
                next_state = PSC_ST_DISABLED;
            end
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state           <= PSC_ST_DISABLED;
            cnt             <= '0;
            work_mode       <= PSC_MODE_OFF;
            i2c_target_addr <= PSC_ADDR_NONE;
            hv_strap        <= 1'b0;
        end else begin
            state           <= next_state;
            cnt             <= next_cnt;
            work_mode       <= next_work_mode;
            i2c_target_addr <= next_addr;
            hv_strap        <= next_hv_strap;
        end
    end

    // ------------------------------------------------------------------
    // output pins
    // ------------------------------------------------------------------
    logic run;
    logic i2c_run;
    logic gpio_run;
    assign run      = (state == PSC_ST_RUN);
    assign i2c_run  = run && (work_mode == PSC_MODE_I2C);
    assign gpio_run = run && (work_mode == PSC_MODE_GPIO);

    logic         next_debug_n;
    logic         next_out_a;
    logic         next_out_a_oe;
    logic         next_plug;
    logic         next_plug_oe;
    logic         next_out_b;
    logic         next_attn_oe;
    logic         next_sw_oe;
    logic         next_sys_en;
    logic         next_i2c_act;
    logic         next_bc_en;
    logic         next_hvcp;
    psc_request_t next_req;
    logic         any_fault;

    always_comb begin
        any_fault = |faults;
        next_sys_en  = run;
        // [RULE_01] push-pull debug indicator
        next_debug_n = run ? ~debug_accessory : PSC_DEBUG_N_RST;
        // [RULE_04] host-set level on dual pin a
        next_out_a_oe = i2c_run && host_cfg.out_a_en;
        next_out_a    = next_out_a_oe && host_cfg.out_a_level;
        // [RULE_06] plug side on mode strap pin
        next_plug_oe = i2c_run && host_cfg.out_plug_en;
        next_plug    = next_plug_oe && cc2_attached;
        // [RULE_13] [RULE_14] fault or general output
        if (i2c_run && host_cfg.out_b_general) begin
            next_out_b = host_cfg.out_b_level;
        end else if (run) begin
            next_out_b = any_fault;
        end else begin
            next_out_b = PSC_FAULT_RST;
        end
        // [RULE_11] [RULE_15] [RULE_16] attention pull-down
        next_attn_oe = i2c_run && (host_cfg.attn_req || flag_s);
        // [RULE_17] [RULE_15] switch closed by pull-down only when clean
        next_sw_oe = run && !any_fault &&
                     !(flag_s && !host_cfg.flag_int_only);
        // [RULE_09] shared pins handed to serial target
        next_i2c_act = i2c_run;
        // [RULE_02] [RULE_03] charger detection gating
        next_bc_en = run && !next_out_a_oe;
        next_hvcp  = next_bc_en && hv_strap && dcp_detected;
        // [RULE_07] [RULE_08] gpio request, clipped to maximum
        next_req = '0;
        if (gpio_run) begin
            next_req.vsel = (voltage_select_input > PSC_VSEL_MAX) ?
                            PSC_VSEL_MAX : voltage_select_input;
            next_req.isel = (current_select_input > PSC_ISEL_MAX) ?
                            PSC_ISEL_MAX : current_select_input;
        end
    end

    // all pins registered so no decode glitch reaches the board
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            debug_n                       <= PSC_DEBUG_N_RST;
            general_output_a              <= 1'b0;
            general_output_a_oe           <= 1'b0;
            plug_side_out                 <= 1'b0;
            plug_side_oe                  <= 1'b0;
            general_output_b              <= PSC_FAULT_RST;
            attn_n_oe                     <= 1'b0;
            vbus_switch_oe                <= 1'b0;
            system_enable                 <= 1'b0;
            i2c_pins_active               <= 1'b0;
            bc_detect_enable              <= 1'b0;
            high_voltage_charger_protocol <= 1'b0;
            gpio_request                  <= '0;
        end else begin
            debug_n                       <= next_debug_n;
            general_output_a              <= next_out_a;
            general_output_a_oe           <= next_out_a_oe;
            plug_side_out                 <= next_plug;
            plug_side_oe                  <= next_plug_oe;
            general_output_b              <= next_out_b;
            attn_n_oe                     <= next_attn_oe;
            vbus_switch_oe                <= next_sw_oe;
            system_enable                 <= next_sys_en;
            i2c_pins_active               <= next_i2c_act;
            bc_detect_enable              <= next_bc_en;
            high_voltage_charger_protocol <= next_hvcp;
            gpio_request                  <= next_req;
        end
    end

    // open-drain data is always low; only the enables move
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            attn_n_o      <= 1'b0;
            vbus_switch_o <= 1'b0;
        end else begin
            attn_n_o      <= 1'b0;
            vbus_switch_o <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    sequence s_fault_seen;
        run && (|faults);
    endsequence

    AST_DEBUG_LEVEL: assert property (@(posedge clk_sys) disable iff (rst)
        run |=> (debug_n == !$past(debug_accessory))) // [RULE_01]
        else $error("debug pin does not follow accessory");
    AST_HV_GROUNDED: assert property (@(posedge clk_sys) disable iff (rst)
        !hv_strap |=> !high_voltage_charger_protocol) // [RULE_02]
        else $error("hv detection with strap low");
    AST_HV_AFTER_DCP: assert property (@(posedge clk_sys) disable iff (rst)
        high_voltage_charger_protocol |-> $past(dcp_detected)) // [RULE_03]
        else $error("hv detection before dcp");
    AST_OUT_A_LEVEL: assert property (@(posedge clk_sys) disable iff (rst)
        general_output_a_oe |-> general_output_a ==
        $past(host_cfg.out_a_level)) // [RULE_04]
        else $error("dual pin a level wrong");
    AST_ADDR_DECODE: assert property (@(posedge clk_sys) disable iff (rst)
        (state == PSC_ST_SAMPLE && en_s && cnt == PSC_STRAP_CNT_LAST &&
         mode_strap == PSC_STRAP_HIGH) |=>
        (i2c_target_addr == 7'h62 && work_mode == PSC_MODE_I2C)) // [RULE_05]
        else $error("strap high not decoded");
    AST_PLUG_SIDE: assert property (@(posedge clk_sys) disable iff (rst)
        plug_side_oe |-> plug_side_out == $past(cc2_attached)) // [RULE_06]
        else $error("plug side level wrong");
    AST_GPIO_CAP: assert property (@(posedge clk_sys) disable iff (rst)
        gpio_request.vsel <= 3'h5 && gpio_request.isel <= 4'h8) // [RULE_08]
        else $error("gpio request above limit");
    AST_FAULT_OUT: assert property (@(posedge clk_sys) disable iff (rst)
        (s_fault_seen and !(i2c_run && host_cfg.out_b_general)) |=>
        general_output_b) // [RULE_13]
        else $error("fault output not raised");
    AST_FLAG_SWITCH: assert property (@(posedge clk_sys) disable iff (rst)
        (flag_input && !host_cfg.flag_int_only) [*3] |=>
        !vbus_switch_oe) // [RULE_15]
        else $error("flag did not open switch");
    AST_DISABLED: assert property (@(posedge clk_sys) disable iff (rst)
        chip_enable_n [*4] |=> !system_enable && !vbus_switch_oe)
        // [RULE_18]
        else $error("system active while disabled");

endmodule // psc_pin_ctrl

// ===== verilog/psc_pkg.sv
// package: constants, enums and carrier types of the sink pin control block
package psc_pkg;

    // ------------------------------------------------------------------
    // strap decode and addresses
    // ------------------------------------------------------------------
    localparam logic [6:0] PSC_ADDR_STRAP_HIGH = 7'h62;
    localparam logic [6:0] PSC_ADDR_STRAP_LOW  = 7'h42;
    localparam logic [6:0] PSC_ADDR_NONE       = 7'h00;

    // ------------------------------------------------------------------
    // gpio mode request limits (voltage code 0..5, current code 0..8)
    // ------------------------------------------------------------------
    localparam logic [2:0] PSC_VSEL_MAX = 3'h5;   // 28 V
    localparam logic [3:0] PSC_ISEL_MAX = 4'h8;   // 3.25 A

    // ------------------------------------------------------------------
    // timing: strap settle after enable, in ns, and derived cycles
    // ------------------------------------------------------------------
    localparam int PSC_CLK_PERIOD_NS   = 5;
    localparam int PSC_STRAP_SETTLE_NS = 100;
    localparam int PSC_STRAP_CYCLES    =
        (PSC_STRAP_SETTLE_NS + PSC_CLK_PERIOD_NS - 1) / PSC_CLK_PERIOD_NS;
    localparam logic [4:0] PSC_STRAP_CNT_LAST =
        5'(PSC_STRAP_CYCLES - 1);

    // ------------------------------------------------------------------
    // reset values of outputs
    // ------------------------------------------------------------------
    localparam logic PSC_DEBUG_N_RST = 1'b1;   // no accessory
    localparam logic PSC_FAULT_RST   = 1'b0;

    // three-state strap level as seen by the pad comparators
    typedef enum logic [1:0] {
        PSC_STRAP_LOW   = 2'b00,
        PSC_STRAP_HIGH  = 2'b01,
        PSC_STRAP_FLOAT = 2'b10
    } psc_strap_t;

    // working mode picked by the strap
    typedef enum logic [1:0] {
        PSC_MODE_OFF  = 2'b00,
        PSC_MODE_I2C  = 2'b01,
        PSC_MODE_GPIO = 2'b10
    } psc_mode_t;

    // enable sequencer
    typedef enum logic [1:0] {
        PSC_ST_DISABLED = 2'b00,
        PSC_ST_SAMPLE   = 2'b01,
        PSC_ST_RUN      = 2'b10
    } psc_state_t;

    // host configuration written over the serial bus (core side)
    typedef struct packed {
        logic out_a_en;      // dual pin a as output
        logic out_a_level;
        logic out_plug_en;   // mode strap pin as output
        logic out_b_general; // multipurpose output as general output
        logic out_b_level;
        logic flag_int_only; // flag input only raises attention
        logic attn_req;      // core asks for attention
    } psc_host_cfg_t;

    // fault events from analog and policy logic
    typedef struct packed {
        logic supply_short;  // adapter cannot supply request
        logic ovp;
        logic uvp;
        logic otp;
    } psc_fault_t;

    // decoded gpio mode power request
    typedef struct packed {
        logic [2:0] vsel;
        logic [3:0] isel;
    } psc_request_t;

endpackage : psc_pkg
